// ---- shared/lb_pkg.sv ----
// Shared constants and types for the line buffer receive control block
package lb_pkg;

  // Device clock rate
  localparam int unsigned CLK_HZ          = 200_000_000;
  // Oversampling factor of the receive bit clock
  localparam int unsigned OVERSAMPLE      = 16;
  // Line buffer capacity in printable characters
  localparam int unsigned LINE_MAX        = 132;
  localparam logic [7:0]  LINE_MAX_C      = 8'(LINE_MAX);
  // Least count of characters taken while busy and ungated
  localparam int unsigned BUSY_ACCEPT_MIN = 5;

  // Character codes that steer the block
  localparam logic [7:0] CH_CR       = 8'h0d;
  localparam logic [7:0] CH_LF       = 8'h0a;
  localparam logic [7:0] CH_FF       = 8'h0c;
  localparam logic [7:0] CH_VT       = 8'h0b;
  localparam logic [7:0] CH_DC1      = 8'h11;
  localparam logic [7:0] CH_DC3      = 8'h13;
  localparam logic [7:0] CH_PRINT_LO = 8'h20;
  localparam logic [7:0] CH_PRINT_HI = 8'h7e;

  // Serial rates in baud
  localparam int unsigned BAUD_110  = 110;
  localparam int unsigned BAUD_150  = 150;
  localparam int unsigned BAUD_200  = 200;
  localparam int unsigned BAUD_300  = 300;
  localparam int unsigned BAUD_600  = 600;
  localparam int unsigned BAUD_1200 = 1200;
  localparam int unsigned BAUD_2400 = 2400;
  localparam int unsigned BAUD_4800 = 4800;
  localparam int unsigned BAUD_9600 = 9600;

  // Rate select codes
  localparam logic [2:0] RATE_110  = 3'h0;
  localparam logic [2:0] RATE_150  = 3'h1;
  localparam logic [2:0] RATE_300  = 3'h2;
  localparam logic [2:0] RATE_1200 = 3'h3;
  localparam logic [2:0] RATE_2400 = 3'h4;
  localparam logic [2:0] RATE_4800 = 3'h5;
  localparam logic [2:0] RATE_9600 = 3'h6;

  // Width of the bit clock divider
  localparam int unsigned DIV_W = 17;

  // Reset values
  localparam logic ONLINE_RST = 1'b1;
  localparam logic BANK_RST   = 1'b0;

  // Baud rate for a select code; the alternate set swaps two entries
  function automatic int unsigned baud_of(input logic [2:0] sel, input logic alt);
    int unsigned b;
    b = BAUD_9600;
    case (sel)
      RATE_110:  b = BAUD_110;
      RATE_150:  b = alt ? BAUD_200 : BAUD_150;
      RATE_300:  b = BAUD_300;
      RATE_1200: b = BAUD_1200;
      RATE_2400: b = BAUD_2400;
      RATE_4800: b = alt ? BAUD_600 : BAUD_4800;
      default:   b = BAUD_9600;
    endcase
    return b;
  endfunction

  // Clock cycles per oversample tick, rounded down
  function automatic logic [DIV_W-1:0] div_of(input logic [2:0] sel, input logic alt);
    return DIV_W'(CLK_HZ / (OVERSAMPLE * baud_of(sel, alt)));
  endfunction

  // Strap options
  typedef struct packed {
    logic line_end_decode_option;
    logic alt_rate_option;
    logic flow_char_option;
    logic ready_not_busy_option;
    logic inverted_reverse_channel_option;
    logic busy_gating_option;
    logic serial_data_gating_option;
    logic half_duplex_option;
  } opt_s;

  // One received character with its strobe
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } rx_char_s;

  // Line fill states
  typedef enum logic [1:0] {
    FILL = 2'b00,
    HOLD = 2'b01
  } fill_e;

endpackage

// ---- rtl/baud_tick_gen.sv ----
// Oversample tick divider for the selected serial rate
`timescale 1ns/100ps
`default_nettype none
module baud_tick_gen
  import lb_pkg::*;
(
  input  wire logic       i_clk,      // Device clock
  input  wire logic       i_rst,      // Asynchronous reset, high
  input  wire logic [2:0] i_rate_sel, // Rate select code
  input  wire logic       i_alt,      // Alternate rate set
  output logic            o_tick      // One cycle per oversample period
);

  // All state of the divider
  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic             tick;
  } div_s;

  div_s st_r;   // Registered state
  div_s st_nxt; // Next state

  // Count down; reload on each tick so a rate change lands within one period
  always_comb
  begin
    st_nxt      = st_r;
    st_nxt.tick = 1'b0;
    if (st_r.cnt == '0)
    begin
      st_nxt.cnt  = DIV_W'(div_of(i_rate_sel, i_alt) - 1'b1);
      st_nxt.tick = 1'b1;
    end
    else
    begin
      st_nxt.cnt = DIV_W'(st_r.cnt - 1'b1);
    end
  end

  // State register
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign o_tick = st_r.tick;

  // A tick never repeats in the next cycle at any offered rate
  a_tick_spacing: assert property (@(posedge i_clk) disable iff (i_rst)
    o_tick |=> !o_tick)
    else $error("baud tick repeated back to back");

endmodule // baud_tick_gen
`default_nettype wire

// ---- rtl/line_buffer_receive_control.sv ----
// Receive side line buffer control: fills, releases and gates print lines
//
// Contract
// - Hold up to 132 characters per line.
// - Plain mode: release on CR or 132.
// - Decode mode: CR, LF, FF, VT or 132.
// - Base rate set 110 through 9600 baud.
// - Alternate set swaps in 200 and 600.
// - Flow option: DC1 on line, DC3 off.
// - DTR on line, optionally also not busy.
// - Reverse channel busy, optionally inverted.
// - Ungated: keep storing characters while busy.
// - Gated: discard characters arriving while busy.
// - Half duplex or serial gating forces gating.
`timescale 1ns/100ps
`default_nettype none
module line_buffer_receive_control
  import lb_pkg::*;
(
  input  wire logic           I_CLK,          // Device clock
  input  wire logic           I_RST,          // Asynchronous reset, high
  input  wire lb_pkg::opt_s   I_OPTS,         // Strap options
  input  wire logic [2:0]     I_RATE_SEL,     // Serial rate select
  input  wire lb_pkg::rx_char_s I_RX_CHAR,    // Received character strobe
  input  wire logic           I_PRINT_BUSY,   // Print mechanism busy
  input  wire logic [7:0]     I_RD_ADDR,      // Read index into released line
  output logic                O_LINE_READY,   // Pulse: a line was released
  output logic [7:0]          O_LINE_LEN,     // Length of released line
  output logic [7:0]          O_RD_DATA,      // Character at read index
  output logic                O_ONLINE,       // On line state
  output logic                O_DTR,          // Data terminal ready
  output logic                O_REV_CHAN,     // Reverse channel line
  output logic                O_CHAR_DROPPED, // Pulse: a character was discarded
  output logic                O_BAUD_TICK     // Oversample tick of the serial rate
);

  // All state of the block
  typedef struct packed {
    fill_e      state;      // Filling or waiting to release
    logic       bank;       // Bank being filled; the other is printing
    logic [7:0] count;      // Characters in the filling bank
    logic       online;     // On line flag
    logic       dtr;        // DTR output
    logic       rev;        // Reverse channel output
    logic       line_ready; // Release pulse
    logic [7:0] line_len;   // Released length
    logic [7:0] rd_data;    // Read data
    logic       dropped;    // Discard pulse
  } st_s;

  st_s        st_r;          // Registered state
  st_s        st_nxt;        // Next state
  logic       wr_en;         // Store the incoming character
  logic       gate_eff;      // Effective busy gating
  logic       is_print;      // Incoming character is printable
  logic       is_term;       // Incoming character ends a line
  logic       is_dc1;        // Flow on character, option enabled
  logic       is_dc3;        // Flow off character, option enabled
  logic       release_now;   // A held line goes to the printer

  // Two line banks: one fills while the printer reads the other, so that when ungated,
  // characters arriving during a busy period are stored until the filling line is frozen
  logic [7:0] line_mem [2][LINE_MAX];

  // Character classification
  always_comb
  begin
    gate_eff = I_OPTS.busy_gating_option | I_OPTS.half_duplex_option
             | I_OPTS.serial_data_gating_option;
    is_print = (I_RX_CHAR.data >= CH_PRINT_LO) && (I_RX_CHAR.data <= CH_PRINT_HI);
    is_term  = (I_RX_CHAR.data == CH_CR)
             || (I_OPTS.line_end_decode_option
                 && ((I_RX_CHAR.data == CH_LF) || (I_RX_CHAR.data == CH_FF)
                     || (I_RX_CHAR.data == CH_VT)));
    is_dc1   = I_OPTS.flow_char_option && (I_RX_CHAR.data == CH_DC1);
    is_dc3   = I_OPTS.flow_char_option && (I_RX_CHAR.data == CH_DC3);
  end

  // Next state: release, character handling, handshake lines, read port
  always_comb
  begin
    st_nxt            = st_r;
    st_nxt.line_ready = 1'b0;
    st_nxt.dropped    = 1'b0;
    wr_en             = 1'b0;
    release_now       = (st_r.state == HOLD) && !I_PRINT_BUSY;
    // A held line leaves once the printer has finished the previous one
    if (release_now)
    begin
      st_nxt.line_ready = 1'b1;
      st_nxt.line_len   = st_r.count;
      st_nxt.bank       = !st_r.bank;
      st_nxt.count      = 8'h00;
      st_nxt.state      = FILL;
    end
    if (I_RX_CHAR.valid)
    begin
      // Arms overlap (a flow character while off line, a gated strobe while
      // holding), so the first true arm wins rather than a one-hot match
      priority case (1'b1)
        // Flow characters act even while off line
        is_dc1:
          st_nxt.online = 1'b1;
        is_dc3:
          st_nxt.online = 1'b0;
        // Off line: the host should not be sending
        !st_r.online:
          st_nxt.dropped = 1'b1;
        // Gated strobe: discard while busy
        gate_eff && I_PRINT_BUSY:
          st_nxt.dropped = 1'b1;
        // A full or ended line is frozen until it leaves
        st_r.state == HOLD:
          st_nxt.dropped = 1'b1;
        // Line end request
        is_term:
          st_nxt.state = HOLD;
        // Store printable characters, busy or not when ungated
        is_print:
        begin
          wr_en        = 1'b1;
          st_nxt.count = 8'(st_r.count + 8'h01);
          if (st_r.count == 8'(LINE_MAX_C - 8'h01))
            st_nxt.state = HOLD;
        end
        // Other control codes are ignored
        default:
          st_nxt.dropped = 1'b0;
      endcase
    end
    // Handshake lines follow the updated on line flag and busy input
    st_nxt.dtr = st_nxt.online
               && (!I_OPTS.ready_not_busy_option || !I_PRINT_BUSY);
    st_nxt.rev = I_OPTS.inverted_reverse_channel_option ? !I_PRINT_BUSY
                                                          : I_PRINT_BUSY;
    // Printer reads the bank not being filled
    if (I_RD_ADDR < LINE_MAX_C)
      st_nxt.rd_data = line_mem[!st_r.bank][I_RD_ADDR];
    else
      st_nxt.rd_data = 8'h00;
  end

  // State register
  always_ff @(posedge I_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      st_r <= '{state: FILL, bank: BANK_RST, count: 8'h00, online: ONLINE_RST,
                dtr: 1'b0, rev: 1'b0, line_ready: 1'b0, line_len: 8'h00,
                rd_data: 8'h00, dropped: 1'b0};
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // Line bank write; storage needs no reset
  always_ff @(posedge I_CLK)
  begin
    if (wr_en)
      line_mem[st_r.bank][st_r.count] <= I_RX_CHAR.data;
  end

  // Serial rate divider for the receiver
  baud_tick_gen u_baud (
    .i_clk      (I_CLK),
    .i_rst      (I_RST),
    .i_rate_sel (I_RATE_SEL),
    .i_alt      (I_OPTS.alt_rate_option),
    .o_tick     (O_BAUD_TICK)
  );

  // Outputs straight from the state register
  assign O_LINE_READY   = st_r.line_ready;
  assign O_LINE_LEN     = st_r.line_len;
  assign O_RD_DATA      = st_r.rd_data;
  assign O_ONLINE       = st_r.online;
  assign O_DTR          = st_r.dtr;
  assign O_REV_CHAN     = st_r.rev;
  assign O_CHAR_DROPPED = st_r.dropped;

  // Checks
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);

  // A line end accepted while filling
  sequence s_term_in;
    I_RX_CHAR.valid && is_term && !is_dc1 && !is_dc3 && st_r.online
      && !(gate_eff && I_PRINT_BUSY) && (st_r.state == FILL);
  endsequence

  // Printer free in the holding cycle
  sequence s_printer_free;
    (st_r.state == HOLD) && !I_PRINT_BUSY;
  endsequence

  // Ungated printable character stored while filling
  sequence s_store;
    I_RX_CHAR.valid && is_print && st_r.online && !gate_eff
      && (st_r.state == FILL);
  endsequence

  a_term_release: assert property (
    s_term_in ##1 s_printer_free |=> O_LINE_READY && (O_LINE_LEN == $past(st_r.count)))
    else $error("line end did not release the line");

  a_lf_ignored: assert property (
    I_RX_CHAR.valid && (I_RX_CHAR.data == CH_LF) && !I_OPTS.line_end_decode_option
      && st_r.online && !(gate_eff && I_PRINT_BUSY) && (st_r.state == FILL)
      |=> (st_r.state == FILL) && $stable(st_r.count))
    else $error("line feed ended a line with decode off");

  a_full_line: assert property (
    s_store ##0 (st_r.count == 8'd131) |=> (st_r.state == HOLD) && (st_r.count == 8'd132))
    else $error("full line not held for release");

  a_count_clear: assert property (
    O_LINE_READY |-> (st_r.count == 8'h00) && (st_r.state == FILL))
    else $error("count not cleared after release");

  a_count_bound: assert property (
    st_r.count <= 8'd132)
    else $error("line count beyond capacity");

  a_busy_store: assert property (
    s_store ##0 I_PRINT_BUSY ##0 (st_r.count < 8'd131)
      |=> st_r.count == 8'($past(st_r.count) + 8'h01))
    else $error("character lost while busy and ungated");

  a_busy_discard: assert property (
    I_RX_CHAR.valid && gate_eff && I_PRINT_BUSY && !is_dc1 && !is_dc3
      && (st_r.state == FILL) |=> O_CHAR_DROPPED && $stable(st_r.count))
    else $error("character kept while busy and gated");

  a_flow_off: assert property (
    I_RX_CHAR.valid && is_dc3 |=> !O_ONLINE ##1 (!O_DTR || !$past(I_RX_CHAR.valid)))
    else $error("flow off character did not take the block off line");

  a_flow_inert: assert property (
    I_RX_CHAR.valid && !I_OPTS.flow_char_option
      && ((I_RX_CHAR.data == CH_DC1) || (I_RX_CHAR.data == CH_DC3))
      |=> $stable(O_ONLINE))
    else $error("flow character changed state with option off");

  a_dtr_busy: assert property (
    I_OPTS.ready_not_busy_option && I_PRINT_BUSY |=> !O_DTR)
    else $error("ready line raised while busy");

  a_dtr_online: assert property (
    !I_OPTS.ready_not_busy_option |=> O_DTR == O_ONLINE)
    else $error("ready line does not follow on line state");

  a_rev_chan: assert property (
    1'b1 |=> O_REV_CHAN == ($past(I_PRINT_BUSY)
                            ^ $past(I_OPTS.inverted_reverse_channel_option)))
    else $error("reverse channel polarity wrong");

  a_force_gate: assert property (
    (I_OPTS.half_duplex_option || I_OPTS.serial_data_gating_option)
      && I_RX_CHAR.valid && I_PRINT_BUSY && !is_dc1 && !is_dc3
      |=> O_CHAR_DROPPED)
    else $error("gating not forced by duplex or serial option");

  // A held line waits while the printer is still busy
  a_hold_wait: assert property (
    (st_r.state == HOLD) && I_PRINT_BUSY |=> !O_LINE_READY && (st_r.state == HOLD))
    else $error("line released while printer busy");

  // The release strobe never stretches into a second cycle
  a_ready_pulse: assert property (
    O_LINE_READY |=> !O_LINE_READY)
    else $error("release pulse longer than one cycle");

  // A line end is not stored and freezes the line
  a_term_not_stored: assert property (
    s_term_in |=> (st_r.state == HOLD) && $stable(st_r.count))
    else $error("line end stored or line not frozen");

  // Flow on character brings the block back on line, never dropped
  a_flow_on: assert property (
    I_RX_CHAR.valid && is_dc1 |=> O_ONLINE && !O_CHAR_DROPPED)
    else $error("flow on character did not take the block on line");

  // Off line, every ordinary character is discarded
  a_offline_drop: assert property (
    I_RX_CHAR.valid && !st_r.online && !is_dc1 && !is_dc3 |=> O_CHAR_DROPPED)
    else $error("character kept while off line");

  // Off line holds the ready line low whatever the options
  a_dtr_offline: assert property (
    !O_ONLINE |-> !O_DTR)
    else $error("ready line high while off line");

  // A frozen line takes no more characters
  a_hold_drop: assert property (
    I_RX_CHAR.valid && is_print && (st_r.state == HOLD) |=> O_CHAR_DROPPED)
    else $error("character stored into a held line");

  // Indices past the line read as zero
  a_read_range: assert property (
    (I_RD_ADDR >= LINE_MAX_C) |=> (O_RD_DATA == 8'h00))
    else $error("read beyond line end gave data");

endmodule // line_buffer_receive_control
`default_nettype wire

// ---- dv/host_model.sv ----
// Host side model that strobes print characters into the block
`timescale 1ns/100ps
`default_nettype none
module host_model
  import lb_pkg::*;
(
  input  wire logic             i_clk,  // Device clock
  output var  lb_pkg::rx_char_s o_char  // Character strobe toward the block
);
  // Idle at time zero with an arbitrary data pattern
  initial o_char = '{valid: 1'b0, data: 8'h5a};

  // One-cycle strobe launched on a falling edge; afterwards the data lines
  // carry the inverse so that a stale character never passes for a fresh one
  task automatic send(input logic [7:0] ch);
    @(negedge i_clk);
    o_char = '{valid: 1'b1, data: ch};
    @(negedge i_clk);
    o_char = '{valid: 1'b0, data: ~ch};
  endtask
endmodule // host_model
`default_nettype wire

// ---- dv/tb.sv ----
// Self-checking bench for the line buffer receive control block
`timescale 1ns/100ps
`default_nettype none
module tb;
  import lb_pkg::*;
  logic       clk       = 1'b0;      // Device clock
  logic       rst       = 1'b1;      // Reset, high
  opt_s       opts      = '0;        // Strap options
  logic [2:0] rate      = RATE_9600; // Rate select
  logic       busy      = 1'b0;      // Printer busy
  logic [7:0] rd_addr   = 8'h00;     // Read index into released line
  rx_char_s   rx_char;               // Driven by the host model
  logic       line_ready;            // Release pulse
  logic       online;                // On line flag
  logic       dtr;                   // Ready line
  logic       rev_chan;              // Reverse channel line
  logic       dropped;               // Discard pulse
  logic       tick;                  // Oversample tick
  logic [7:0] line_len;              // Released length
  logic [7:0] rd_data;               // Released character
  int         n_fail    = 0;         // Mismatches
  int         cmp_count = 0;         // Comparisons
  int         n_drop    = 0;         // Discard pulses seen
  int         n_rel     = 0;         // Releases seen
  int         seed      = 32'hc151;  // Fixed seed
  int         d;                     // Scratch counter snapshot
  logic [7:0] exp_q[$];              // Expected line lengths, oldest first
  logic [7:0] terms[4] = '{CH_CR, CH_LF, CH_FF, CH_VT}; // Decode mode enders

  // Free running 200 MHz clock
  always #2.5 clk = ~clk;

  line_buffer_receive_control u_line_buffer_receive_control (
    .I_CLK          (clk),
    .I_RST          (rst),
    .I_OPTS         (opts),
    .I_RATE_SEL     (rate),
    .I_RX_CHAR      (rx_char),
    .I_PRINT_BUSY   (busy),
    .I_RD_ADDR      (rd_addr),
    .O_LINE_READY   (line_ready),
    .O_LINE_LEN     (line_len),
    .O_RD_DATA      (rd_data),
    .O_ONLINE       (online),
    .O_DTR          (dtr),
    .O_REV_CHAN     (rev_chan),
    .O_CHAR_DROPPED (dropped),
    .O_BAUD_TICK    (tick)
  );

  host_model u_host_model (
    .i_clk  (clk),
    .o_char (rx_char)
  );

  // Compares and counts; a mismatch is reported at once
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    cmp_count++;
    if (seen !== want)
    begin
      n_fail++;
      $display("unexpected at %0t: saw %0h expected %0h", $time, seen, want);
    end
  endtask

  // Single exit point of the run
  task automatic end_sim();
    $display("Compares %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Pulses are one cycle wide, so they are sampled mid-cycle
  always @(negedge clk)
  begin
    if (dropped === 1'b1)
      n_drop++;
    if (line_ready === 1'b1)
    begin
      n_rel++;
      if (exp_q.size() == 0)
        check(line_len, 32'h1ff);
      else
        check(line_len, exp_q.pop_front());
    end
  end

  // Bounded wait for one more release; a stall ends the run
  task automatic wait_rel();
    int start;
    start = n_rel;
    for (int i = 0; i < 40 && n_rel == start; i++)
      cyc(1);
    if (n_rel == start)
    begin
      n_fail++;
      $display("unexpected at %0t: no release", $time);
      end_sim();
    end
  endtask

  // Random printable character
  function automatic logic [7:0] rnd_char();
    return CH_PRINT_LO + 8'($unsigned($random(seed)) % 95);
  endfunction

  // Sends n printables and an optional ender, then expects one release
  task automatic send_line(input int n, input logic [7:0] term, input logic [7:0] len);
    exp_q.push_back(len);
    for (int i = 0; i < n; i++)
      u_host_model.send(rnd_char());
    if (term != 8'h00)
      u_host_model.send(term);
    wait_rel();
  endtask

  // Read port answers one cycle after the index
  task automatic rd(input logic [7:0] a, input logic [7:0] want);
    rd_addr = a;
    cyc(1);
    check(rd_data, want);
  endtask

  // Cycles to the next tick, bounded so a dead divider cannot hang the run
  task automatic wait_tick(output int n);
    n = 0;
    do
    begin
      cyc(1);
      n++;
    end
    while (tick !== 1'b1 && n < 30000);
    if (n >= 30000)
    begin
      n_fail++;
      $display("unexpected at %0t: no tick", $time);
      end_sim();
    end
  endtask

  // Old period may still run once after a select change, so skip two ticks
  task automatic meas(input logic [2:0] sel, input logic alt, input int baud);
    int n;
    opts.alt_rate_option = alt;
    rate = sel;
    wait_tick(n);
    wait_tick(n);
    wait_tick(n);
    check(n, 200_000_000 / (16 * baud));
  endtask

  // Main sequence
  initial
  begin
    cyc(5);
    rst = 1'b0;
    cyc(2);
    check(online, 1'b1);
    // Plain mode: line feed is ignored, carriage return ends the line
    exp_q.push_back(8'h02);
    u_host_model.send(8'h41);
    u_host_model.send(CH_LF);
    u_host_model.send(8'h42);
    u_host_model.send(CH_CR);
    wait_rel();
    rd(8'h00, 8'h41);
    rd(8'h01, 8'h42);
    rd(LINE_MAX_C, 8'h00);
    // A full line releases itself, the next one starts from zero
    send_line(LINE_MAX, 8'h00, LINE_MAX_C);
    send_line(1, CH_CR, 8'h01);
    opts.line_end_decode_option = 1'b1;
    foreach (terms[i])
      send_line(i + 1, terms[i], 8'(i + 1));
    // Flow characters switch the on line state only when enabled
    opts.flow_char_option = 1'b1;
    u_host_model.send(CH_DC3);
    cyc(2);
    check(online, 1'b0);
    check(dtr, 1'b0);
    d = n_drop;
    u_host_model.send(8'h41);
    cyc(2);
    check(n_drop - d, 1);
    u_host_model.send(CH_DC1);
    cyc(2);
    check(online, 1'b1);
    opts.flow_char_option = 1'b0;
    u_host_model.send(CH_DC3);
    cyc(2);
    check(online, 1'b1);
    // Every combination of handshake options and busy
    for (int i = 0; i < 8; i++)
    begin
      {opts.ready_not_busy_option, opts.inverted_reverse_channel_option, busy} = 3'(i);
      cyc(3);
      check(dtr, !(opts.ready_not_busy_option && busy));
      check(rev_chan, busy ^ opts.inverted_reverse_channel_option);
    end
    // Ungated and busy: characters still stored, line waits for idle
    opts.ready_not_busy_option = 1'b0;
    opts.inverted_reverse_channel_option = 1'b0;
    d = n_drop;
    exp_q.push_back(8'(BUSY_ACCEPT_MIN));
    repeat (BUSY_ACCEPT_MIN)
      u_host_model.send(rnd_char());
    u_host_model.send(CH_CR);
    cyc(3);
    check(n_drop - d, 0);
    // The ended line is frozen, so a further character is discarded
    u_host_model.send(rnd_char());
    cyc(2);
    check(n_drop - d, 1);
    busy = 1'b0;
    wait_rel();
    // Each gating option alone discards while busy
    for (int k = 0; k < 3; k++)
    begin
      opts[2:0] = 3'b001 << k;
      busy = 1'b1;
      d = n_drop;
      u_host_model.send(rnd_char());
      cyc(2);
      check(n_drop - d, 1);
      busy = 1'b0;
      cyc(2);
    end
    opts[2:0] = 3'b000;
    send_line(2, CH_CR, 8'h02);
    // Reset in mid run: back on line, ready line low while held
    opts.flow_char_option = 1'b1;
    u_host_model.send(CH_DC3);
    cyc(1);
    rst = 1'b1;
    cyc(2);
    check(online, 1'b1);
    check(dtr, 1'b0);
    opts.flow_char_option = 1'b0;
    rst = 1'b0;
    cyc(2);
    check(dtr, 1'b1);
    // Rate sets, including the swapped 4800 entry (600 in the alternate set)
    meas(RATE_9600, 1'b0, 9600);
    meas(RATE_4800, 1'b0, 4800);
    meas(RATE_4800, 1'b1, 600);
    end_sim();
  end
endmodule // tb
`default_nettype wire
